// [core/dcsc_defs.vh]
// register map, field layout, reset values and timing for the dc servo control block
`ifndef DCSC_DEFS_VH
`define DCSC_DEFS_VH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define DCSC_IDX_ENABLE   7'h43
`define DCSC_IDX_TRIGGER  7'h44
`define DCSC_IDX_INTERVAL 7'h45
`define DCSC_IDX_CNT_LINE 7'h47
`define DCSC_IDX_CNT_HP   7'h48
`define DCSC_IDX_DONE     7'h4D
`define DCSC_IDX_IRQ_STAT 7'h50
`define DCSC_IDX_IRQ_MASK 7'h51

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define DCSC_TRIG_SINGLE_LSB  12
`define DCSC_TRIG_SERIES_LSB  8
`define DCSC_TRIG_POWERUP_LSB 4
`define DCSC_TRIG_SWOFS_LSB   0
`define DCSC_IVL_LINE_LSB     8
`define DCSC_IVL_HP_LSB       0
`define DCSC_DONE_LSB         8

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define DCSC_RST_ENABLE   4'h0
`define DCSC_RST_INTERVAL 16'h0AAA
`define DCSC_RST_COUNT    7'h2A
`define DCSC_RST_MASK     4'h0

// -----------------------------------------------------------------
// correction modes driven to the analogue servo
// -----------------------------------------------------------------
`define DCSC_MODE_PERIODIC 3'h0
`define DCSC_MODE_SINGLE   3'h1
`define DCSC_MODE_SERIES   3'h2
`define DCSC_MODE_POWERUP  3'h3
`define DCSC_MODE_SWOFS    3'h4

// -----------------------------------------------------------------
// timing: base periodic step and clock period
// -----------------------------------------------------------------
`define DCSC_STEP_NS  256000000
`define DCSC_CLK_NS   5
`define DCSC_STEP_CYC (`DCSC_STEP_NS / `DCSC_CLK_NS)

`define DCSC_RESP_OKAY   2'h0
`define DCSC_RESP_SLVERR 2'h2

`endif

// [core/dcsc_top.v]
// dc offset servo control registers with axi4-lite slave and correction sequencer
`timescale 1ns/10ps
`include "dcsc_defs.vh"

module dcsc_top #(
   parameter        ADDR_W    = 9,
   parameter [31:0] STEP_CYC  = `DCSC_STEP_CYC
) (
   // clock and reset
   input  wire              aclk,
   input  wire              aresetn,
   // axi4-lite write address and data
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   // axi4-lite read
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // analogue servo side
   output reg  [3:0]        servo_en,
   output reg  [3:0]        corr_start,
   output reg  [11:0]       corr_mode,
   input  wire [3:0]        corr_done,
   // interrupt
   output reg               irq
);

   // -----------------------------------------------------------------
   // register state
   // -----------------------------------------------------------------
   reg [15:0]       trig_q;
   reg [3:0]        ivl_line_q;
   reg [3:0]        ivl_hp_q;
   reg [1:0]        ivl_spare_q;
   reg [6:0]        cnt_line_q;
   reg [6:0]        cnt_hp_q;
   reg [3:0]        done_q;
   reg [3:0]        stat_q;
   reg [3:0]        mask_q;

   // write channel capture
   reg              aw_held_q;
   reg              w_held_q;
   reg [6:0]        aw_idx_q;
   reg [15:0]       w_data_q;
   reg [1:0]        w_strb_q;

   // -----------------------------------------------------------------
   // decode helpers
   // -----------------------------------------------------------------
   // register index from a byte address
   function [6:0] dcsc_index;
      input [ADDR_W-1:0] addr;
      begin
         dcsc_index = addr[8:2];
      end
   endfunction

   // true when the index names a mapped register
   function dcsc_mapped;
      input [6:0] idx;
      begin
         case (idx)
            `DCSC_IDX_ENABLE, `DCSC_IDX_TRIGGER, `DCSC_IDX_INTERVAL,
            `DCSC_IDX_CNT_LINE, `DCSC_IDX_CNT_HP, `DCSC_IDX_DONE,
            `DCSC_IDX_IRQ_STAT, `DCSC_IDX_IRQ_MASK: dcsc_mapped = 1'b1;
            default: dcsc_mapped = 1'b0;
         endcase
      end
   endfunction

   // -----------------------------------------------------------------
   // axi write path
   // -----------------------------------------------------------------
   wire        do_wr    = aw_held_q & w_held_q & ~s_axi_bvalid;
   wire        wr_ena   = do_wr & (aw_idx_q == `DCSC_IDX_ENABLE);
   wire        wr_trig  = do_wr & (aw_idx_q == `DCSC_IDX_TRIGGER);
   wire        wr_ivl   = do_wr & (aw_idx_q == `DCSC_IDX_INTERVAL);
   wire        wr_cl    = do_wr & (aw_idx_q == `DCSC_IDX_CNT_LINE);
   wire        wr_ch    = do_wr & (aw_idx_q == `DCSC_IDX_CNT_HP);
   wire        wr_mask  = do_wr & (aw_idx_q == `DCSC_IDX_IRQ_MASK);
   // trigger bits only count where their byte lane was written
   wire [15:0] trig_wr  = {{8{wr_trig & w_strb_q[1]}}, {8{wr_trig & w_strb_q[0]}}}
                          & w_data_q;

   // address and data are taken in either order, one write at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DCSC_RESP_OKAY;
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_idx_q      <= 7'h00;
         w_data_q      <= 16'h0000;
         w_strb_q      <= 2'h0;
      end else begin
         s_axi_awready <= ~aw_held_q & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready  <= ~w_held_q & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_q     <= 1'b1;
            aw_idx_q      <= dcsc_index(s_axi_awaddr);
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_q     <= 1'b1;
            w_data_q     <= s_axi_wdata[15:0];
            w_strb_q     <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= dcsc_mapped(aw_idx_q) ? `DCSC_RESP_OKAY : `DCSC_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   // reset image of the interval word, sliced per field so no bits are dropped
   wire [15:0] ivl_rst = `DCSC_RST_INTERVAL;

   always @(posedge aclk) begin
      if (!aresetn) begin
         servo_en    <= `DCSC_RST_ENABLE;
         ivl_line_q  <= ivl_rst[`DCSC_IVL_LINE_LSB +: 4];
         ivl_hp_q    <= ivl_rst[`DCSC_IVL_HP_LSB +: 4];
         ivl_spare_q <= 2'h3;
         cnt_line_q  <= `DCSC_RST_COUNT;
         cnt_hp_q    <= `DCSC_RST_COUNT;
         mask_q      <= `DCSC_RST_MASK;
      end else begin
         if (wr_ena & w_strb_q[0])
            servo_en <= w_data_q[3:0];
         if (wr_ivl & w_strb_q[1])
            ivl_line_q <= w_data_q[`DCSC_IVL_LINE_LSB +: 4];
         if (wr_ivl & w_strb_q[0]) begin
            ivl_hp_q    <= w_data_q[`DCSC_IVL_HP_LSB +: 4];
            ivl_spare_q <= {w_data_q[7], w_data_q[5]};
         end
         if (wr_cl & w_strb_q[0])
            cnt_line_q <= w_data_q[6:0];
         if (wr_ch & w_strb_q[0])
            cnt_hp_q <= w_data_q[6:0];
         if (wr_mask & w_strb_q[0])
            mask_q <= w_data_q[3:0];
      end
   end

   // -----------------------------------------------------------------
   // periodic timers: one 0.256 s step shared, one exponent counter per pair
   // -----------------------------------------------------------------
   reg  [31:0] step_q;
   reg  [15:0] tcnt_q [0:1];
   reg  [1:0]  hit_q;
   wire        step   = (step_q == STEP_CYC - 32'd1);
   wire [3:0]  ivl [0:1];
   assign ivl[0] = ivl_hp_q;
   assign ivl[1] = ivl_line_q;

   // a long count is split so the exponent counter stays 16 bits wide
   always @(posedge aclk) begin
      if (!aresetn)
         step_q <= 32'h00000000;
      else
         step_q <= step ? 32'h00000000 : step_q + 32'd1;
   end

   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_pair
         wire [15:0] period = 16'h0001 << ivl[p];
         // zero code switches the pair's periodic updates off
         always @(posedge aclk) begin
            if (!aresetn) begin
               tcnt_q[p] <= 16'h0000;
               hit_q[p]  <= 1'b0;
            end else begin
               hit_q[p] <= 1'b0;
               if (ivl[p] == 4'h0) begin
                  tcnt_q[p] <= 16'h0000;
               end else if (step) begin
                  if (tcnt_q[p] >= period - 16'h0001) begin
                     tcnt_q[p] <= 16'h0000;
                     hit_q[p]  <= 1'b1;
                  end else begin
                     tcnt_q[p] <= tcnt_q[p] + 16'h0001;
                  end
               end
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // per-channel correction sequencer
   // -----------------------------------------------------------------
   localparam ST_IDLE = 1'b0;
   localparam ST_WAIT = 1'b1;

   reg  [3:0]  st_q;
   reg  [3:0]  pend_q;
   reg  [7:0]  left_q [0:3];
   wire [3:0]  fin;

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_ch
         // channels 2 and 3 are the line pair, 0 and 1 the headphone pair
         wire [6:0] cnt  = (i >= 2) ? cnt_line_q : cnt_hp_q;
         wire       hit  = hit_q[i / 2];
         wire       t_su = trig_wr[`DCSC_TRIG_POWERUP_LSB + i];
         wire       t_dw = trig_wr[`DCSC_TRIG_SWOFS_LSB + i];
         wire       t_se = trig_wr[`DCSC_TRIG_SERIES_LSB + i];
         wire       t_si = trig_wr[`DCSC_TRIG_SINGLE_LSB + i];
         wire       go   = t_su | t_dw | t_se | t_si;
         // enable as it stands after this edge, so a disable never races a launch
         wire       en_nx = (wr_ena & w_strb_q[0]) ? w_data_q[i] : servo_en[i];
         assign fin[i] = (st_q[i] == ST_WAIT) & en_nx & corr_done[i] & (left_q[i] == 8'h00);

         // launch priority: power-up, software offset, series, single, periodic
         always @(posedge aclk) begin
            if (!aresetn) begin
               st_q[i]                 <= ST_IDLE;
               left_q[i]               <= 8'h00;
               pend_q[i]               <= 1'b0;
               corr_start[i]           <= 1'b0;
               corr_mode[3*i +: 3]     <= `DCSC_MODE_PERIODIC;
               trig_q[12 + i]          <= 1'b0;
               trig_q[8 + i]           <= 1'b0;
               trig_q[4 + i]           <= 1'b0;
               trig_q[i]               <= 1'b0;
               done_q[i]               <= 1'b0;
            end else begin
               corr_start[i] <= 1'b0;
               if (hit & en_nx)
                  pend_q[i] <= 1'b1;
               case (st_q[i])
                  ST_IDLE: begin
                     left_q[i] <= 8'h00;
                     if (en_nx & go) begin
                        st_q[i]       <= ST_WAIT;
                        corr_start[i] <= 1'b1;
                        if (t_su) begin
                           corr_mode[3*i +: 3] <= `DCSC_MODE_POWERUP;
                           trig_q[4 + i]       <= 1'b1;
                           done_q[i]           <= 1'b0;
                        end else if (t_dw) begin
                           corr_mode[3*i +: 3] <= `DCSC_MODE_SWOFS;
                           trig_q[i]           <= 1'b1;
                           done_q[i]           <= 1'b0;
                        end else if (t_se) begin
                           corr_mode[3*i +: 3] <= `DCSC_MODE_SERIES;
                           trig_q[8 + i]       <= 1'b1;
                           left_q[i]           <= {1'b0, cnt};
                        end else begin
                           corr_mode[3*i +: 3] <= `DCSC_MODE_SINGLE;
                           trig_q[12 + i]      <= 1'b1;
                        end
                     end else if (en_nx & pend_q[i]) begin
                        st_q[i]             <= ST_WAIT;
                        corr_start[i]       <= 1'b1;
                        pend_q[i]           <= 1'b0;
                        corr_mode[3*i +: 3] <= `DCSC_MODE_PERIODIC;
                     end
                  end
                  ST_WAIT: begin
                     if (!en_nx) begin
                        // disabling a channel abandons its correction
                        st_q[i]        <= ST_IDLE;
                        trig_q[12 + i] <= 1'b0;
                        trig_q[8 + i]  <= 1'b0;
                        trig_q[4 + i]  <= 1'b0;
                        trig_q[i]      <= 1'b0;
                     end else if (corr_done[i]) begin
                        if (left_q[i] != 8'h00) begin
                           left_q[i]     <= left_q[i] - 8'h01;
                           corr_start[i] <= 1'b1;
                        end else begin
                           st_q[i]        <= ST_IDLE;
                           trig_q[12 + i] <= 1'b0;
                           trig_q[8 + i]  <= 1'b0;
                           trig_q[4 + i]  <= 1'b0;
                           trig_q[i]      <= 1'b0;
                           if (trig_q[4 + i] | trig_q[i])
                              done_q[i] <= 1'b1;
                        end
                     end
                  end
                  default: st_q[i] <= ST_IDLE;
               endcase
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // interrupt status: finish events are sticky, a read clears them
   // -----------------------------------------------------------------
   wire rd_go   = s_axi_arvalid & s_axi_arready;
   wire [6:0] rd_idx = dcsc_index(s_axi_araddr);
   wire rd_stat = rd_go & (rd_idx == `DCSC_IDX_IRQ_STAT);

   // a finish in the clearing cycle survives the clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= 4'h0;
         irq    <= 1'b0;
      end else begin
         stat_q <= (rd_stat ? 4'h0 : stat_q) | fin;
         irq    <= |(((rd_stat ? 4'h0 : stat_q) | fin) & mask_q);
      end
   end

   // -----------------------------------------------------------------
   // axi read path
   // -----------------------------------------------------------------
   reg [15:0] rd_val;

   // read mux; unmapped indices read zero
   always @* begin
      case (rd_idx)
         `DCSC_IDX_ENABLE:   rd_val = {12'h000, servo_en};
         // a running software offset also lights its series bit
         `DCSC_IDX_TRIGGER:  rd_val = {trig_q[15:12], trig_q[11:8] | trig_q[3:0],
                                       trig_q[7:0]};
         `DCSC_IDX_INTERVAL: rd_val = {4'h0, ivl_line_q, ivl_spare_q[1], 1'b0,
                                       ivl_spare_q[0], 1'b0, ivl_hp_q};
         `DCSC_IDX_CNT_LINE: rd_val = {9'h000, cnt_line_q};
         `DCSC_IDX_CNT_HP:   rd_val = {9'h000, cnt_hp_q};
         `DCSC_IDX_DONE:     rd_val = {4'h0, done_q, 8'h00};
         `DCSC_IDX_IRQ_STAT: rd_val = {12'h000, stat_q};
         `DCSC_IDX_IRQ_MASK: rd_val = {12'h000, mask_q};
         default:            rd_val = 16'h0000;
      endcase
   end

   // one read at a time; data answers the cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `DCSC_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~rd_go;
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, rd_val};
            s_axi_rresp   <= dcsc_mapped(rd_idx) ? `DCSC_RESP_OKAY : `DCSC_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// [test/dcsc_props.sv]
// property checker for the dc servo control register block
`timescale 1ns/10ps
module dcsc_props #(
   parameter ADDR_W = 9
) (
   // clock and reset
   input wire              aclk,
   input wire              aresetn,
   // write channels
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire              s_axi_awvalid,
   input wire              s_axi_awready,
   input wire [31:0]       s_axi_wdata,
   input wire [3:0]        s_axi_wstrb,
   input wire              s_axi_wvalid,
   input wire              s_axi_wready,
   input wire [1:0]        s_axi_bresp,
   input wire              s_axi_bvalid,
   input wire              s_axi_bready,
   // read channels
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire              s_axi_arvalid,
   input wire              s_axi_arready,
   input wire [31:0]       s_axi_rdata,
   input wire [1:0]        s_axi_rresp,
   input wire              s_axi_rvalid,
   input wire              s_axi_rready,
   // servo side and interrupt
   input wire [3:0]        servo_en,
   input wire [3:0]        corr_start,
   input wire [11:0]       corr_mode,
   input wire [3:0]        corr_done,
   input wire              irq
);
   // one clock domain, so one clocking and one disable for all
   default clocking dcsc_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_bresp_stable: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early");
   a_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped early");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no write response");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("no read response");
   a_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid held after handshake");
   a_no_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while response pending");
   a_start_single: assert property ((corr_start & $past(corr_start)) == 4'h0)
      else $error("update request longer than one cycle");
   a_start_enabled: assert property ((corr_start & ~servo_en) == 4'h0)
      else $error("update request on a disabled channel");
   a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_awready &&
      servo_en == 4'h0 && corr_start == 4'h0) else $error("outputs busy after reset");
endmodule

bind dcsc_top dcsc_props #(.ADDR_W(ADDR_W)) u_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .servo_en(servo_en),
   .corr_start(corr_start), .corr_mode(corr_mode), .corr_done(corr_done), .irq(irq)
);

// [test/dcsc_top_tb.sv]
// self-checking bench for the dc servo control register block
`timescale 1ns/10ps
module dcsc_top_tb;
   // ----------
   // signals
   // ----------
   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic [8:0]  awaddr  = 9'h000;
   logic [8:0]  araddr  = 9'h000;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'hF;
   logic [3:0]  corr_done = 4'h0;
   wire         awready, wready, bvalid, arready, rvalid, irq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [3:0]  servo_en, corr_start;
   wire  [11:0] corr_mode;
   int          err_count  = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   int          t;
   // table rows: index, write value, readback, response
   logic [6:0]  r_idx [6] = '{7'h43, 7'h45, 7'h47, 7'h48, 7'h51, 7'h46};
   logic [15:0] r_wd  [6] = '{16'hFFFF, 16'h0FA1, 16'h007F, 16'h0000, 16'h00FF, 16'h1234};
   logic [15:0] r_rd  [6] = '{16'h000F, 16'h0FA1, 16'h007F, 16'h0000, 16'h000F, 16'h0000};
   logic [1:0]  r_rsp [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
   // per mode: trigger bit on channel k, expected mode code
   int          bpos  [4] = '{12, 5, 2, 11};
   logic [2:0]  emode [4] = '{3'h1, 3'h3, 3'h4, 3'h2};
   // readback while running; software offset also lights its series bit
   logic [15:0] erd   [4] = '{16'h1000, 16'h0020, 16'h0404, 16'h0800};

   // short step so periodic timing fits in the run
   dcsc_top #(.ADDR_W(9), .STEP_CYC(32'h4)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .servo_en(servo_en), .corr_start(corr_start), .corr_mode(corr_mode),
      .corr_done(corr_done), .irq(irq)
   );

   // 200 MHz clock
   initial begin
      forever #2.5 aclk = ~aclk;
   end

   // ----------
   // tasks
   // ----------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [6:0] idx, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr  <= {idx, 2'h0};
      wdata   <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      // bready follows bvalid by a cycle so a stalled response is exercised
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid === 1'b1 && bready === 1'b1));
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [6:0] idx, input logic [15:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr  <= {idx, 2'h0};
      arvalid <= 1'b1;
      // rready follows rvalid by a cycle so stalled read data is exercised
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid === 1'b1 && rready === 1'b1));
      rready <= 1'b0;
      chk("rdata", rdata, {16'h0000, e});
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask

   // analogue side reports n finished updates on one channel
   task automatic fin(input int ch, input int n);
      repeat (n) begin
         repeat (3) @(posedge aclk);
         corr_done <= 4'h1 << ch;
         @(posedge aclk);
         corr_done <= 4'h0;
      end
   endtask

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, well above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         summarize();
      end
   end

   // ----------
   // tests
   // ----------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(r_idx[i], r_wd[i], r_rsp[i]);
         rd(r_idx[i], r_rd[i], r_rsp[i]);
      end
      $display("test table done");
      // second reset in mid-run, then reset values
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(7'h43, 16'h0000, 2'h0);
      rd(7'h44, 16'h0000, 2'h0);
      rd(7'h45, 16'h0AAA, 2'h0);
      rd(7'h47, 16'h002A, 2'h0);
      rd(7'h48, 16'h002A, 2'h0);
      $display("test reset done");
      // timers off so no periodic update steals a finish; only channel 1 unmasked
      wr(7'h45, 16'h00A0, 2'h0);
      wr(7'h47, 16'h0001, 2'h0);
      wr(7'h51, 16'h0002, 2'h0);
      wr(7'h43, 16'h000F, 2'h0);
      for (int k = 0; k < 4; k++) begin
         wr(7'h44, 16'h1 << bpos[k], 2'h0);
         chk("corr_mode", {29'h0, corr_mode[3*k +: 3]}, {29'h0, emode[k]});
         rd(7'h44, erd[k], 2'h0);
         fin(k, (k == 3) ? 2 : 1);
         rd(7'h44, 16'h0000, 2'h0);
         chk("irq", {31'h0, irq}, {31'h0, k >= 1});
      end
      rd(7'h4D, 16'h0600, 2'h0);
      rd(7'h50, 16'h000F, 2'h0);
      repeat (2) @(posedge aclk);
      chk("irq", {31'h0, irq}, 32'h0);
      $display("test modes done");
      // low byte lane off: the count register must keep its value
      wstrb <= 4'h2;
      wr(7'h47, 16'h0055, 2'h0);
      wstrb <= 4'hF;
      rd(7'h47, 16'h0001, 2'h0);
      // trigger on a disabled channel is ignored
      wr(7'h43, 16'h000E, 2'h0);
      wr(7'h44, 16'h1000, 2'h0);
      rd(7'h44, 16'h0000, 2'h0);
      // shortest headphone interval launches a periodic update
      wr(7'h45, 16'h00A1, 2'h0);
      t = 0;
      while (corr_start[1] !== 1'b1 && t < 100) begin
         @(posedge aclk);
         t++;
      end
      chk("periodic_mode", {29'h0, corr_mode[5:3]}, 32'h0);
      chk("periodic_seen", {31'h0, t < 100}, 32'h1);
      $display("test refuse and periodic done");
      summarize();
   end
endmodule
